// >>> shared/ascr_pkg.sv
// Constants for the converter configuration register bank
package ascr_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] CHIP_LO = 8'h00;
  localparam logic [7:0] CHIP_HI = 8'h02;
  localparam logic [7:0] PROG_LO = 8'h08;
  localparam logic [7:0] PROG_HI = 8'h2a;
  localparam logic [7:0] XFER_ADDR = 8'hff;
  localparam logic [7:0] PORT_ADDR = 8'h00;
  localparam logic [7:0] CHIPID_ADDR = 8'h01;
  localparam logic [7:0] GRADE_ADDR = 8'h02;
  localparam logic [7:0] CLK_ADDR = 8'h09;
  localparam logic [7:0] PORT_RESET = 8'h18;
  localparam logic [7:0] CLK_RESET = 8'h01;
  localparam logic [7:0] PORT_FIXED = 8'h18;
  localparam int unsigned PORT_LSB_HI = 6;
  localparam int unsigned PORT_LSB_LO = 1;
  localparam int unsigned PORT_SRST_HI = 5;
  localparam int unsigned PORT_SRST_LO = 2;
  localparam int unsigned CLK_DCS_BIT = 0;
  localparam int unsigned XFER_BIT = 0;
  localparam int unsigned PROG_N = 35;
  localparam logic [7:0] ZERO8 = 8'h00;
endpackage : ascr_pkg

// >>> core/ascr_regs.sv
// Register bank of the converter serial configuration port
`timescale 1ns/1ps
`default_nettype none
module ascr_regs #(
  parameter logic [7:0] CHIP_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] CHIP_GRADE = 8'h00 // Arbitrary value
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic addr_ok_o,
  output logic lsb_first_o,
  output logic soft_reset_o,
  output logic dcs_en_o,
  output logic [279:0] prog_active_o
);
  localparam int unsigned N = ascr_pkg::PROG_N;
  logic [7:0] port_reg, next_port_reg;
  logic [7:0] clk_shadow, next_clk_shadow;
  logic [7:0] clk_active, next_clk_active;
  logic [7:0] shadow [N];
  logic [7:0] active [N];
  // Writable port setup bits: both mirrored fields
  localparam logic [7:0] LSB_MASK =
    8'((1 << ascr_pkg::PORT_LSB_HI) | (1 << ascr_pkg::PORT_LSB_LO));
  localparam logic [7:0] SRST_MASK =
    8'((1 << ascr_pkg::PORT_SRST_HI) | (1 << ascr_pkg::PORT_SRST_LO));
  localparam logic [7:0] PORT_WR_MASK = LSB_MASK | SRST_MASK;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic in_chip;
  logic in_prog;
  logic in_xfer;
  logic xfer_go;
  logic wr_port;
  logic wr_clk;
  logic soft_pending;
  logic [5:0] idx;

  // Region decode
  assign in_chip = addr_i <= ascr_pkg::CHIP_HI;
  assign in_prog = (addr_i >= ascr_pkg::PROG_LO) && (addr_i <= ascr_pkg::PROG_HI);
  assign in_xfer = addr_i == ascr_pkg::XFER_ADDR;
  assign idx = 6'(addr_i - ascr_pkg::PROG_LO);
  assign addr_ok_o = in_chip | in_prog | in_xfer;
  // Transfer bit self-clears: acts on the write, never stored
  assign xfer_go = wr_en_i && in_xfer && wdata_i[ascr_pkg::XFER_BIT];
  assign wr_port = wr_en_i && (addr_i == ascr_pkg::PORT_ADDR);
  assign wr_clk = wr_en_i && (addr_i == ascr_pkg::CLK_ADDR);
  assign soft_pending = |(port_reg & SRST_MASK);

  always_comb begin
    next_port_reg = port_reg;
    if (wr_port) begin
      // Bits 4 and 3 fixed; 7 and 0 reserved
      next_port_reg = (wdata_i & PORT_WR_MASK) | ascr_pkg::PORT_FIXED;
    end else if (soft_pending) begin
      // Soft reset returns port setup to default
      next_port_reg = ascr_pkg::PORT_RESET;
    end
  end

  always_comb begin
    next_clk_shadow = clk_shadow;
    next_clk_active = clk_active;
    if (wr_clk) begin
      next_clk_shadow = wdata_i;
    end
    if (xfer_go) begin
      next_clk_active = clk_shadow;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_reg <= ascr_pkg::PORT_RESET;
      clk_shadow <= ascr_pkg::CLK_RESET;
      clk_active <= ascr_pkg::CLK_RESET;
      rdata <= ascr_pkg::ZERO8;
    end else begin
      port_reg <= next_port_reg;
      clk_shadow <= next_clk_shadow;
      clk_active <= next_clk_active;
      rdata <= next_rdata;
    end
  end

  // Registers without defaults: no reset term, keep contents
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_prog
      logic [7:0] next_sh, next_ac;
      always_comb begin
        next_sh = shadow[g];
        next_ac = active[g];
        if (wr_en_i && in_prog && idx == 6'(g)) begin
          next_sh = wdata_i;
        end
        if (xfer_go) begin
          next_ac = shadow[g];
        end
      end
      always_ff @(posedge mclk_i) begin
        shadow[g] <= next_sh;
        active[g] <= next_ac;
      end
      assign prog_active_o[g*8 +: 8] = active[g];
    end
  endgenerate

  always_comb begin
    next_rdata = ascr_pkg::ZERO8;
    if (rd_en_i) begin
      case (addr_i)
        ascr_pkg::PORT_ADDR: begin
          next_rdata = port_reg;
        end
        ascr_pkg::CHIPID_ADDR: begin
          next_rdata = CHIP_ID;
        end
        ascr_pkg::GRADE_ADDR: begin
          next_rdata = CHIP_GRADE;
        end
        ascr_pkg::CLK_ADDR: begin
          // Clock register reads back the staged value
          next_rdata = clk_shadow;
        end
        default: begin
          // Transfer register and holes read as zero
          if (in_prog) begin
            next_rdata = shadow[idx];
          end
        end
      endcase
    end
  end

  assign rdata_o = rdata;
  assign lsb_first_o = port_reg[ascr_pkg::PORT_LSB_HI] | port_reg[ascr_pkg::PORT_LSB_LO];
  assign soft_reset_o = soft_pending;
  assign dcs_en_o = clk_active[ascr_pkg::CLK_DCS_BIT];
endmodule : ascr_regs
`default_nettype wire

// >>> testbench/ascr_asserts.sv
// Register bank checker
`timescale 1ns/1ps
`default_nettype none
module ascr_chk (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic addr_ok_o,
  input wire logic dcs_en_o,
  input wire logic lsb_first_o,
  input wire logic soft_reset_o,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  sequence rd_s(x); rd_en_i && !wr_en_i && addr_i == x; endsequence
  sequence port_idle_s; !(wr_en_i && addr_i == 8'h00); endsequence
  sequence port_dflt_s; !soft_reset_o && !lsb_first_o; endsequence
  soft_clr_a: assert property (soft_reset_o ##0 port_idle_s |=> port_dflt_s)
    else $error("soft reset did not clear");
  dec_ok_a: assert property (addr_ok_o ==
    (addr_i inside {[8'h00:8'h02], [8'h08:8'h2a], 8'hff})) else $error("decode");
  port_fix_a: assert property (rd_s(8'h00) |=> (rdata_o & 8'h99) == 8'h18)
    else $error("port");
  dcs_hold_a: assert property (!(wr_en_i && addr_i == 8'hff) |=> $stable(dcs_en_o))
    else $error("dcs");
  rst_load_a: assert property ($rose(resetn_i) |-> dcs_en_o && !lsb_first_o)
    else $error("reset");
  lsb_mir_a: assert property (wr_en_i && addr_i == 8'h00 |=>
    lsb_first_o == |($past(wdata_i) & 8'h42)) else $error("lsb");
  soft_pulse_a: assert property (wr_en_i && addr_i == 8'h00 && |(wdata_i & 8'h24) |=>
    soft_reset_o) else $error("soft");
  xfer_clr_a: assert property (rd_s(8'hff) |=> rdata_o == 8'h00) else $error("xfer");
  unmap_rd_a: assert property (rd_en_i && !wr_en_i && !addr_ok_o |=>
    rdata_o == 8'h00) else $error("unmapped");
endmodule : ascr_chk
bind ascr_regs ascr_chk u_chk (.*);
`default_nettype wire

// >>> testbench/ascr_host.sv
// Host model for the register strobes
`timescale 1ns/1ps
`default_nettype none
module ascr_host (input wire logic mclk_i, output logic wr_en_o, rd_en_o,
  output logic [7:0] addr_o, wdata_o);
  initial {wr_en_o, rd_en_o, addr_o, wdata_o} = 18'h0;
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(negedge mclk_i) {wr_en_o, rd_en_o, addr_o, wdata_o} = {w, !w, a, d};
    @(negedge mclk_i) {wr_en_o, rd_en_o} = 2'b00;
  endtask : acc
endmodule : ascr_host
`default_nettype wire

// >>> testbench/testbench.sv
// Register bank bench
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk_i = 0, resetn_i = 0, wr_en_i, rd_en_i, addr_ok_o, dcs_en_o;
  logic lsb_first_o, soft_reset_o;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic [279:0] prog_active_o;
  int n_mismatch = 0, comparisons = 0;
  initial forever #50 mclk_i = ~mclk_i;
  ascr_host i_host (.mclk_i, .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i),
    .wdata_o(wdata_i));
  ascr_regs i_dut (.*);
  task automatic ck(input string n, input logic [7:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask : ck
  task automatic op(input string n, input logic w, input logic [7:0] a, d, e);
    i_host.acc(w, a, d);
    ck(n, w ? {4'h0, addr_ok_o, lsb_first_o, soft_reset_o, dcs_en_o} : rdata_o, e);
  endtask : op
  task automatic summarize;
    $display("%0d errors in %0d checks", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  initial begin
    #100000 n_mismatch++;
    summarize();
  end
  initial begin
    repeat (12) @(negedge mclk_i);
    resetn_i = 1;
    op("port setup", 0, 8'h00, 8'h00, 8'h18);
    op("clock staged", 1, 8'h09, 8'h00, 8'h09);
    op("clock readback", 0, 8'h09, 8'h00, 8'h00);
    op("clock applied", 1, 8'hff, 8'h01, 8'h08);
    op("transfer read", 0, 8'hff, 8'h00, 8'h00);
    op("port write", 1, 8'h00, 8'h66, 8'h0e);
    op("port restored", 0, 8'h00, 8'h00, 8'h18);
    op("program write", 1, 8'h2a, 8'h5c, 8'h08);
    op("program readback", 0, 8'h2a, 8'h00, 8'h5c);
    op("program applied", 1, 8'hff, 8'h01, 8'h08);
    ck("program active", prog_active_o[279:272], 8'h5c);
    resetn_i = 0;
    @(negedge mclk_i) resetn_i = 1;
    ck("program kept", prog_active_o[279:272], 8'h5c);
    ck("stabilizer reset", {7'h00, dcs_en_o}, 8'h01);
    op("unmapped read", 0, 8'h2b, 8'h00, 8'h00);
    summarize();
  end
endmodule : testbench
`default_nettype wire
